/* tx_path_pkg.sv */
// Constants, field layouts and state types for the per-channel transmit configuration bank.
// Assumes a single 32-bit AHB-Lite master and eight identical transmit channels.
package tx_path_pkg;

	// Channel count and bus address width
	localparam int CHANNELS = 8;
	localparam int ADDR_WIDTH = 12;

	// Register indices; byte address is four times the index
	localparam logic [7:0] TX_CONFIG_0_INDEX = 8'h02;
	localparam logic [7:0] TX_CONFIG_1_INDEX = 8'h03;
	localparam logic [7:0] CHANNEL_STRIDE = 8'h20;

	// Field positions of the first register
	localparam int CFG0_POWER_DOWN_BIT = 4;
	localparam int CFG0_INVERT_BIT = 3;
	localparam int CFG0_EDGE_BIT = 2;
	localparam int CFG0_MODE_LSB = 0;

	// Field positions of the second register
	localparam int CFG1_MONITOR_OFF_BIT = 5;
	localparam int CFG1_HIZ_BIT = 4;
	localparam int CFG1_TEMPLATE_LSB = 0;

	// Reset values
	localparam logic [7:0] TX_CONFIG_0_RESET = 8'h00;
	localparam logic [7:0] TX_CONFIG_1_RESET = 8'h10;

	// Stage modes and line symbol codes held in the encoder delay line
	localparam logic [1:0] MODE_SUBST = 2'b00;
	localparam logic [1:0] MODE_AMI = 2'b01;
	localparam logic [1:0] LINE_ZERO = 2'b00;
	localparam logic [1:0] LINE_MARK = 2'b01;
	localparam logic [1:0] LINE_VIOL = 2'b10;

	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;

	// Decoded configuration of one channel
	typedef struct packed {
		logic power_down;
		logic data_invert;
		logic edge_rising;
		logic [1:0] stage_mode;
		logic monitor_disable;
		logic hiz;
		logic [3:0] template_sel;
	} chan_cfg_type;

	// Full state of one channel
	typedef struct packed {
		chan_cfg_type cfg;
		logic [2:0] clk_sync;
		logic [2:0] single_sync;
		logic [2:0] pos_sync;
		logic [2:0] neg_sync;
		logic clk_level;
		logic single_level;
		logic pos_level;
		logic neg_level;
		logic [7:0][1:0] delay;
		logic last_pol;
		logic ones_odd;
		logic line_pos;
		logic line_neg;
		logic oe;
		logic powered;
		logic mon_en;
		logic arb;
		logic rsv;
		logic [3:0] tmpl_out;
	} chan_type;

	// Bus slave state
	typedef struct packed {
		logic wr_pend;
		logic [2:0] wr_chan;
		logic wr_reg;
		logic [31:0] rdata;
		logic ready;
		logic resp;
	} bus_type;

	// Whole block state
	typedef struct packed {
		bus_type bus;
		chan_type [CHANNELS-1:0] ch;
	} state_type;

	// Register image of one configuration byte
	function automatic logic [7:0] pack_cfg(input chan_cfg_type cfg, input logic sel);
		logic [7:0] v;
		v = 8'h00;
		if (!sel) begin
			v[CFG0_POWER_DOWN_BIT] = cfg.power_down;
			v[CFG0_INVERT_BIT] = cfg.data_invert;
			v[CFG0_EDGE_BIT] = cfg.edge_rising;
			v[CFG0_MODE_LSB +: 2] = cfg.stage_mode;
		end else begin
			v[CFG1_MONITOR_OFF_BIT] = cfg.monitor_disable;
			v[CFG1_HIZ_BIT] = cfg.hiz;
			v[CFG1_TEMPLATE_LSB +: 4] = cfg.template_sel;
		end
		return v;
	endfunction

	// Update one configuration byte; reserved bits are dropped
	function automatic chan_cfg_type unpack_cfg(input chan_cfg_type cfg, input logic sel, input logic [7:0] v);
		chan_cfg_type c;
		c = cfg;
		if (!sel) begin
			c.power_down = v[CFG0_POWER_DOWN_BIT];
			c.data_invert = v[CFG0_INVERT_BIT];
			c.edge_rising = v[CFG0_EDGE_BIT];
			c.stage_mode = v[CFG0_MODE_LSB +: 2];
		end else begin
			c.monitor_disable = v[CFG1_MONITOR_OFF_BIT];
			c.hiz = v[CFG1_HIZ_BIT];
			c.template_sel = v[CFG1_TEMPLATE_LSB +: 4];
		end
		return c;
	endfunction

	// Reset image of the whole block
	function automatic state_type reset_state();
		state_type s;
		s = '0;
		s.bus.ready = 1'b1;
		s.bus.resp = HRESP_OKAY;
		for (int c = 0; c < CHANNELS; c++) begin
			s.ch[c].cfg = unpack_cfg(s.ch[c].cfg, 1'b0, TX_CONFIG_0_RESET);
			s.ch[c].cfg = unpack_cfg(s.ch[c].cfg, 1'b1, TX_CONFIG_1_RESET);
			s.ch[c].powered = 1'b1;
			s.ch[c].mon_en = 1'b1;
		end
		return s;
	endfunction

	localparam state_type STATE_RESET = reset_state();

endpackage

/* tx_path_config_regs.sv */
// Per-channel transmit configuration registers and the transmit line coder they steer.
// Assumes one AHB-Lite master on hclk and framer pins that are asynchronous to hclk.
//
// What this block does
// - Eight register pairs, 0x20 index stride apart.
// - Power-down bit stops transmitter, tristates driver.
// - Invert bit selects active-low transmit data.
// - Edge bit: 0 falling, 1 rising clock.
// - Mode 00: zero-substitution coding then shaper.
// - Mode 01: plain AMI, no substitution.
// - Mode 1x: bypass coder, take dual rails.
// - Monitor-disable bit turns driver monitor off.
// - High-impedance bit tristates driver only.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns

module tx_path_config_regs
	import tx_path_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [ADDR_WIDTH-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [CHANNELS-1:0] tx_channel_clock,
	input wire logic [CHANNELS-1:0] tx_single_rail_in,
	input wire logic [CHANNELS-1:0] tx_positive_rail_in,
	input wire logic [CHANNELS-1:0] tx_negative_rail_in,
	output logic [CHANNELS-1:0] line_pos_out,
	output logic [CHANNELS-1:0] line_neg_out,
	output logic [CHANNELS-1:0] line_driver_oe,
	output logic [CHANNELS-1:0] tx_powered,
	output logic [CHANNELS-1:0] driver_fail_monitor_en,
	output logic [CHANNELS-1:0][3:0] pulse_template_select,
	output logic [CHANNELS-1:0] template_arbitrary,
	output logic [CHANNELS-1:0] template_reserved
);

	// Registered state and its next value
	state_type s_q;
	state_type s_d;

	// Address-phase decode results
	logic [ADDR_WIDTH-3:0] addr_index;
	logic addr_ok;
	logic [2:0] addr_chan;
	logic addr_reg;

	// One step of a channel: pin synchronisers, edge detect, coder, output flops
	function automatic chan_type channel_step(input chan_type cur, input logic clk_pin, input logic sr_pin,
			input logic pr_pin, input logic nr_pin);
		chan_type nx;
		logic edge_seen;
		logic bit_in;
		logic e1;
		logic [1:0] out_code;
		logic pol;
		nx = cur;
		pol = cur.last_pol;
		out_code = LINE_ZERO;
		// Three-stage synchronisers; the first stage feeds only the second
		nx.clk_sync = {cur.clk_sync[1:0], clk_pin};
		nx.single_sync = {cur.single_sync[1:0], sr_pin};
		nx.pos_sync = {cur.pos_sync[1:0], pr_pin};
		nx.neg_sync = {cur.neg_sync[1:0], nr_pin};
		// A level counts only once stages two and three agree
		if (cur.clk_sync[2] == cur.clk_sync[1]) begin
			nx.clk_level = cur.clk_sync[1];
		end
		if (cur.single_sync[2] == cur.single_sync[1]) begin
			nx.single_level = cur.single_sync[1];
		end
		if (cur.pos_sync[2] == cur.pos_sync[1]) begin
			nx.pos_level = cur.pos_sync[1];
		end
		if (cur.neg_sync[2] == cur.neg_sync[1]) begin
			nx.neg_level = cur.neg_sync[1];
		end
		// Sampling edge of the transmit clock
		edge_seen = cur.cfg.edge_rising ? (nx.clk_level & ~cur.clk_level) : (~nx.clk_level & cur.clk_level);
		// Data lags the clock through identical synchronisers, so the old level is the one at the edge
		bit_in = cur.single_level ^ cur.cfg.data_invert;
		e1 = (cur.cfg.template_sel[3:1] == 3'b000);
		if (cur.cfg.power_down) begin
			// Transmitter off: coder flushed, no pulses
			nx.delay = '0;
			nx.line_pos = 1'b0;
			nx.line_neg = 1'b0;
			nx.last_pol = 1'b0;
			nx.ones_odd = 1'b0;
		end else if (edge_seen) begin
			if (cur.cfg.stage_mode[1]) begin
				// Coder bypassed, rails taken as they come
				nx.line_pos = cur.pos_level ^ cur.cfg.data_invert;
				nx.line_neg = cur.neg_level ^ cur.cfg.data_invert;
				nx.delay = '0;
			end else begin
				// E1 needs four symbols of look-ahead, T1 eight
				out_code = e1 ? cur.delay[3] : cur.delay[7];
				nx.delay = {cur.delay[6:0], (bit_in ? LINE_MARK : LINE_ZERO)};
				// Symbol leaving the delay line goes to the shaper
				case (out_code)
					LINE_MARK: begin
						pol = ~cur.last_pol;
						nx.line_pos = pol;
						nx.line_neg = ~pol;
						nx.last_pol = pol;
						nx.ones_odd = ~cur.ones_odd;
					end
					LINE_VIOL: begin
						nx.line_pos = cur.last_pol;
						nx.line_neg = ~cur.last_pol;
						nx.ones_odd = 1'b0;
					end
					default: begin
						nx.line_pos = 1'b0;
						nx.line_neg = 1'b0;
					end
				endcase
				// Substitution is decided after the leaving symbol is counted,
				// so a violation sent in this very step already resets the parity
				if (cur.cfg.stage_mode == MODE_SUBST) begin
					if (e1 && (nx.delay[3:0] == 8'h00)) begin
						// Four zeros become 000V or B00V to keep violations alternating
						nx.delay[0] = LINE_VIOL;
						if (!nx.ones_odd) begin
							nx.delay[3] = LINE_MARK;
						end
					end else if (!e1 && (nx.delay == 16'h0000)) begin
						// Eight zeros become 000VB0VB
						nx.delay[4] = LINE_VIOL;
						nx.delay[3] = LINE_MARK;
						nx.delay[1] = LINE_VIOL;
						nx.delay[0] = LINE_MARK;
					end
				end
			end
		end
		// Static controls re-registered so every output leaves a flop
		nx.oe = ~cur.cfg.power_down & ~cur.cfg.hiz;
		nx.powered = ~cur.cfg.power_down;
		nx.mon_en = ~cur.cfg.monitor_disable & ~cur.cfg.power_down;
		nx.tmpl_out = cur.cfg.template_sel;
		nx.arb = (cur.cfg.template_sel[3:2] == 2'b11);
		nx.rsv = (cur.cfg.template_sel[3:2] == 2'b10);
		return nx;
	endfunction

	// Address decode: channel in index bits 7:5, register in bits 4:0
	always_comb begin
		addr_index = haddr[ADDR_WIDTH-1:2];
		addr_chan = addr_index[7:5];
		addr_reg = (addr_index[4:0] == TX_CONFIG_1_INDEX[4:0]);
		addr_ok = (haddr[1:0] == 2'b00) && (addr_index[ADDR_WIDTH-3:8] == '0)
			&& ((addr_index[4:0] == TX_CONFIG_0_INDEX[4:0]) || addr_reg);
	end

	// Next-state logic; nothing moves while the clock enable is low
	always_comb begin
		s_d = s_q;
		if (ce) begin
			// Write data phase lands in the addressed channel
			if (s_q.bus.wr_pend) begin
				s_d.ch[s_q.bus.wr_chan].cfg = unpack_cfg(s_q.ch[s_q.bus.wr_chan].cfg, s_q.bus.wr_reg, hwdata[7:0]);
				s_d.bus.wr_pend = 1'b0;
			end
			// Address phase of a new transfer
			if (hsel && hready && htrans[1]) begin
				s_d.bus.rdata = 32'h0000_0000;
				if (hwrite) begin
					// Unmapped writes are dropped silently
					s_d.bus.wr_pend = addr_ok;
					s_d.bus.wr_chan = addr_chan;
					s_d.bus.wr_reg = addr_reg;
				end else if (addr_ok) begin
					// Read from s_d so a write still in its data phase is seen
					s_d.bus.rdata = {24'h00_0000, pack_cfg(s_d.ch[addr_chan].cfg, addr_reg)};
				end
			end
			// Transmit path of every channel
			for (int c = 0; c < CHANNELS; c++) begin
				s_d.ch[c] = channel_step(s_q.ch[c], tx_channel_clock[c], tx_single_rail_in[c],
					tx_positive_rail_in[c], tx_negative_rail_in[c]);
				if (s_d.bus.wr_pend == 1'b0 && s_q.bus.wr_pend && s_q.bus.wr_chan == c[2:0]) begin
					s_d.ch[c].cfg = unpack_cfg(s_q.ch[c].cfg, s_q.bus.wr_reg, hwdata[7:0]);
				end else begin
					s_d.ch[c].cfg = s_d.ch[c].cfg;
				end
			end
			// A write whose data phase overlaps a new write keeps the new address but still lands
			if (s_q.bus.wr_pend) begin
				s_d.ch[s_q.bus.wr_chan].cfg = unpack_cfg(s_q.ch[s_q.bus.wr_chan].cfg, s_q.bus.wr_reg, hwdata[7:0]);
			end
		end
	end

	// State register; reset loads a constant image only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flops
	always_comb begin
		hrdata = s_q.bus.rdata;
		hreadyout = s_q.bus.ready;
		hresp = s_q.bus.resp;
		for (int c = 0; c < CHANNELS; c++) begin
			line_pos_out[c] = s_q.ch[c].line_pos;
			line_neg_out[c] = s_q.ch[c].line_neg;
			line_driver_oe[c] = s_q.ch[c].oe;
			tx_powered[c] = s_q.ch[c].powered;
			driver_fail_monitor_en[c] = s_q.ch[c].mon_en;
			pulse_template_select[c] = s_q.ch[c].tmpl_out;
			template_arbitrary[c] = s_q.ch[c].arb;
			template_reserved[c] = s_q.ch[c].rsv;
		end
	end

	// Helper terms for the checks on channel 0
	localparam logic [ADDR_WIDTH-1:0] CH7_CFG0_ADDR = 12'h388;
	logic ev0;
	logic bit0;
	assign ev0 = s_q.ch[0].cfg.edge_rising ? (s_d.ch[0].clk_level & ~s_q.ch[0].clk_level)
		: (~s_d.ch[0].clk_level & s_q.ch[0].clk_level);
	assign bit0 = s_q.ch[0].single_level ^ s_q.ch[0].cfg.data_invert;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Channel 7 first register sits seven strides above channel 0
	AST_STRIDE: assert property (ce && hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr == CH7_CFG0_ADDR
		|=> s_q.bus.wr_pend && s_q.bus.wr_chan == 3'd7 && !s_q.bus.wr_reg)
		else $error("channel 7 write not decoded");

	// Powered-down channel drives nothing
	AST_POWER_DOWN: assert property (ce && s_q.ch[0].cfg.power_down
		|=> !line_driver_oe[0] && !line_pos_out[0] && !line_neg_out[0] && !tx_powered[0])
		else $error("powered-down channel still active");

	// Positive bypass rail follows the inverted or plain input at the sampling edge
	AST_DUAL_RAIL: assert property (ce && ev0 && s_q.ch[0].cfg.stage_mode[1] && !s_q.ch[0].cfg.power_down
		|=> line_pos_out[0] == ($past(s_q.ch[0].pos_level) ^ $past(s_q.ch[0].cfg.data_invert)))
		else $error("dual-rail data not taken");

	// Opposite clock edge leaves the line untouched
	AST_EDGE_SELECT: assert property (ce && s_q.ch[0].cfg.stage_mode[1] && !s_q.ch[0].cfg.power_down
		&& !s_q.ch[0].cfg.edge_rising && s_d.ch[0].clk_level && !s_q.ch[0].clk_level
		|=> $stable(line_pos_out[0]) && $stable(line_neg_out[0]))
		else $error("line changed on unselected edge");

	// AMI never inserts a violation
	AST_AMI: assert property (ce && ev0 && s_q.ch[0].cfg.stage_mode == MODE_AMI && !s_q.ch[0].cfg.power_down
		|=> s_q.ch[0].delay[0] != LINE_VIOL)
		else $error("violation inserted in AMI mode");

	// Eight zeros on a T1 template become 000VB0VB
	AST_B8ZS: assert property (ce && ev0 && s_q.ch[0].cfg.stage_mode == MODE_SUBST && !s_q.ch[0].cfg.power_down
		&& s_q.ch[0].cfg.template_sel[3:1] != 3'b000 && s_q.ch[0].delay[6:0] == 14'h0000 && !bit0
		|=> s_q.ch[0].delay[4] == LINE_VIOL && s_q.ch[0].delay[3] == LINE_MARK && s_q.ch[0].delay[0] == LINE_MARK)
		else $error("B8ZS pattern missing");

	// Four zeros on an E1 template end in a violation
	AST_HDB3: assert property (ce && ev0 && s_q.ch[0].cfg.stage_mode == MODE_SUBST && !s_q.ch[0].cfg.power_down
		&& s_q.ch[0].cfg.template_sel[3:1] == 3'b000 && s_q.ch[0].delay[2:0] == 6'h00 && !bit0
		|=> s_q.ch[0].delay[0] == LINE_VIOL)
		else $error("HDB3 violation missing");

	// Monitor follows its disable bit and is also off while the channel is powered down
	AST_MONITOR: assert property (ce
		|=> driver_fail_monitor_en[0] == !($past(s_q.ch[0].cfg.monitor_disable) || $past(s_q.ch[0].cfg.power_down)))
		else $error("driver monitor enable wrong");

	// High impedance alone keeps the transmitter powered
	AST_HIZ: assert property (ce && s_q.ch[0].cfg.hiz && !s_q.ch[0].cfg.power_down
		|=> !line_driver_oe[0] && tx_powered[0])
		else $error("high impedance handling wrong");

	// Template classes
	AST_TEMPLATE: assert property (ce && s_q.ch[0].cfg.template_sel[3:2] == 2'b11
		|=> template_arbitrary[0] && !template_reserved[0])
		else $error("arbitrary template not flagged");

	// Reserved template codes raise only the reserved flag
	AST_RESERVED: assert property (ce && s_q.ch[0].cfg.template_sel[3:2] == 2'b10
		|=> template_reserved[0] && !template_arbitrary[0])
		else $error("reserved template not flagged");

	// Template field is copied to its output one cycle later
	AST_TEMPLATE_COPY: assert property (ce
		|=> pulse_template_select[0] == $past(s_q.ch[0].cfg.template_sel))
		else $error("template output wrong");

	// A write data phase to the first register lands its power-down bit
	AST_WRITE_POWER: assert property (ce && s_q.bus.wr_pend && s_q.bus.wr_chan == 3'd0 && !s_q.bus.wr_reg
		|=> s_q.ch[0].cfg.power_down == $past(hwdata[CFG0_POWER_DOWN_BIT]))
		else $error("power-down bit not written");

	// A write data phase to the second register lands its high-impedance bit
	AST_WRITE_HIZ: assert property (ce && s_q.bus.wr_pend && s_q.bus.wr_chan == 3'd0 && s_q.bus.wr_reg
		|=> s_q.ch[0].cfg.hiz == $past(hwdata[CFG1_HIZ_BIT]))
		else $error("high-impedance bit not written");

	// Powered-down coder holds no symbols, so nothing stale leaks out at power up
	AST_POWER_FLUSH: assert property (ce && s_q.ch[0].cfg.power_down
		|=> s_q.ch[0].delay == '0)
		else $error("coder not flushed at power down");

	// AMI marks alternate polarity on a T1 template
	AST_AMI_POLARITY: assert property (ce && ev0 && s_q.ch[0].cfg.stage_mode == MODE_AMI && !s_q.ch[0].cfg.power_down
		&& s_q.ch[0].cfg.template_sel[3:1] != 3'b000 && s_q.ch[0].delay[7] == LINE_MARK
		|=> line_pos_out[0] == !$past(s_q.ch[0].last_pol) && line_neg_out[0] == $past(s_q.ch[0].last_pol))
		else $error("AMI mark polarity wrong");

	// Negative rail in bypass follows its pin as well
	AST_DUAL_RAIL_NEG: assert property (ce && ev0 && s_q.ch[0].cfg.stage_mode[1] && !s_q.ch[0].cfg.power_down
		|=> line_neg_out[0] == ($past(s_q.ch[0].neg_level) ^ $past(s_q.ch[0].cfg.data_invert)))
		else $error("negative rail not taken");

	// Falling clock edge is ignored when the rising edge is selected
	AST_EDGE_RISING: assert property (ce && s_q.ch[0].cfg.stage_mode[1] && !s_q.ch[0].cfg.power_down
		&& s_q.ch[0].cfg.edge_rising && !s_d.ch[0].clk_level && s_q.ch[0].clk_level
		|=> $stable(line_pos_out[0]) && $stable(line_neg_out[0]))
		else $error("line changed on falling edge");

	// Clock enable low freezes registers and coder alike
	AST_CE_FREEZE: assert property (!ce
		|=> $stable(s_q))
		else $error("state moved with clock enable low");

	// Main scenarios
	COV_HDB3: cover property (s_q.ch[0].cfg.template_sel[3:1] == 3'b000 && s_q.ch[0].delay[0] == LINE_VIOL);
	COV_WRITE_READ: cover property (s_q.bus.wr_pend ##1 (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite));
	COV_B8ZS: cover property (s_q.ch[0].delay[4] == LINE_VIOL);
	COV_POWER_DOWN: cover property (s_q.ch[0].cfg.power_down ##1 !s_q.ch[0].cfg.power_down);

endmodule

/* framer_model.sv */
// Framer model: drives the transmit clock and data pins of all channels alike.
// Assumes the bench supplies the next data bits and the sampling edge in use.
`timescale 1ns/1ns
module framer_model
	import tx_path_pkg::*;
(
	input wire logic run,
	input wire logic edge_rising,
	input wire logic single_d,
	input wire logic pos_d,
	input wire logic neg_d,
	output logic [CHANNELS-1:0] clk_pins,
	output logic [CHANNELS-1:0] single_pins,
	output logic [CHANNELS-1:0] pos_pins,
	output logic [CHANNELS-1:0] neg_pins
);
	// Shared link clock level, idle high
	logic lclk = 1'b1;

	assign clk_pins = {CHANNELS{lclk}};

	// Clock stands still outside frames; released data shows the inverse of its last value
	always begin
		if (!run) begin
			single_pins = ~single_pins;
			pos_pins = ~pos_pins;
			neg_pins = ~neg_pins;
			wait (run);
			// Odd offset keeps link edges off the bus clock edges
			#7;
		end
		#160;
		lclk = ~lclk;
		// Data moves on the unused edge, so it is stable around the sampled one
		if (lclk != edge_rising) begin
			single_pins = {CHANNELS{single_d}};
			pos_pins = {CHANNELS{pos_d}};
			neg_pins = {CHANNELS{neg_d}};
		end
	end

	// Known start levels
	initial begin
		single_pins = '1;
		pos_pins = '1;
		neg_pins = '1;
	end
endmodule

/* tx_path_config_regs_tb.sv */
// Self-checking bench for the transmit configuration bank and its line coder.
// Assumes the framer model drives the link pins and the bench is the only bus master.
`timescale 1ns/1ns
module tx_path_config_regs_tb import tx_path_pkg::*; ;
	// Bus side
	logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
	logic [ADDR_WIDTH-1:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	// Link side
	logic [CHANNELS-1:0] lclk, sr, pr, nr, lpos, lneg, oe, pwr, mon, arb, rsv;
	logic [CHANNELS-1:0][3:0] tmpl;
	// Known before the framer model first looks at it
	logic run = 1'b0;
	logic erise, sd, pd, nd, ep, en, sp, sn, last, hit;
	// Template codes for the flag test: two reserved, two arbitrary
	logic [3:0] tc [4] = '{4'h8, 4'hB, 4'hC, 4'hF};
	logic [7:0] m;
	int error_cnt, compares;
	// Ordinary register cases: channel, register, write value, read-back
	typedef struct {int ch; int r; logic [31:0] wd; logic [31:0] exp;} row_type;
	row_type rows [4] = '{'{0, 0, 32'h0000_00FF, 32'h0000_001F}, '{7, 1, 32'h0000_00FF, 32'h0000_003F},
		'{3, 0, 32'h0000_000A, 32'h0000_000A}, '{5, 1, 32'h0000_0021, 32'h0000_0021}};
	// Template codes and the steady all-zero mark pattern each gives
	logic [31:0] tp [3] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002};
	logic [7:0] pat [3] = '{8'h99, 8'h99, 8'h1B};

	tx_path_config_regs tx_path_config_regs_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_channel_clock(lclk),
		.tx_single_rail_in(sr), .tx_positive_rail_in(pr), .tx_negative_rail_in(nr), .line_pos_out(lpos),
		.line_neg_out(lneg), .line_driver_oe(oe), .tx_powered(pwr), .driver_fail_monitor_en(mon),
		.pulse_template_select(tmpl), .template_arbitrary(arb), .template_reserved(rsv));

	framer_model framer_model_i (.run(run), .edge_rising(erise), .single_d(sd), .pos_d(pd), .neg_d(nd),
		.clk_pins(lclk), .single_pins(sr), .pos_pins(pr), .neg_pins(nr));

	// 25 MHz bus clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// Byte address of a channel's register
	function automatic logic [ADDR_WIDTH-1:0] ra(input int ch, input int r);
		return ADDR_WIDTH'((ch * CHANNEL_STRIDE + TX_CONFIG_0_INDEX + r) * 4);
	endfunction

	// One single transfer; each phase is held until hready is seen high
	task automatic xfer(input logic wr, input logic [ADDR_WIDTH-1:0] a, input logic [31:0] wd);
		haddr <= a;
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Wait one sampled link edge, note the rails there, then read the settled line
	task automatic sym(input logic tog);
		if (erise) @(posedge lclk[0]);
		else @(negedge lclk[0]);
		ep = pr[0];
		en = nr[0];
		@(posedge hclk);
		// Next bit goes out on the unused edge
		if (tog) begin
			pd <= ~pd;
			nd <= ~nd;
		end
		repeat (6) @(posedge hclk);
		sp = lpos[0];
		sn = lneg[0];
	endtask

	// Verdict and end of run
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{ce, hsel, hresetn, hwrite, run, erise, sd, pd, nd} = 9'b1_1000_0010;
		{haddr, htrans, hsize, hwdata} = '0;
		hsize = 3'b010;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({oe, pwr, mon}, 24'h00_FFFF);
		xfer(0, ra(1, 0), 0);
		chk(rd, 32'h0000_0000);
		xfer(0, ra(1, 1), 0);
		chk(rd, 32'h0000_0010);
		// Row loop: back-to-back write then read-back per row
		for (int i = 0; i < 4; i++) begin
			xfer(1, ra(rows[i].ch, rows[i].r), rows[i].wd);
			xfer(0, ra(rows[i].ch, rows[i].r), 0);
			chk(rd, rows[i].exp);
		end
		xfer(0, ra(1, 1), 0);
		chk(rd, 32'h0000_0010);
		chk({mon[7], oe[7], hresp}, 3'b000);
		// Unmapped and misaligned places read zero
		xfer(1, 12'h010, 32'h0000_00FF);
		xfer(0, 12'h010, 0);
		chk(rd, 32'h0000_0000);
		xfer(0, 12'h009, 0);
		chk(rd, 32'h0000_0000);
		// Template codes: reserved and arbitrary flags follow the top bits
		for (int k = 0; k < 4; k++) begin
			xfer(1, ra(0, 1), 32'(tc[k]));
			repeat (2) @(posedge hclk);
			chk(32'({arb[0], rsv[0], tmpl[0]}), 32'({k[1], ~k[1], tc[k]}));
		end
		$display("test registers done");
		// Bypass: both edges, both polarities, rails toggling every bit
		xfer(1, ra(0, 1), 32'h0000_0002);
		run <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			erise <= k[0];
			xfer(1, ra(0, 0), 32'({k[1], k[0], 2'b10}));
			repeat (3) sym(1);
			for (int i = 0; i < 4; i++) begin
				sym(1);
				chk(32'({sp, sn}), 32'({ep ^ k[1], en ^ k[1]}));
			end
		end
		$display("test bypass done");
		// Plain AMI on all ones alternates marks; all zeros stay zeros
		erise <= 1'b0;
		sd <= 1'b1;
		xfer(1, ra(0, 0), 32'h0000_0001);
		repeat (12) sym(0);
		last = sp;
		for (int i = 0; i < 8; i++) begin
			sym(0);
			chk(32'({sp, sn}), 32'({~last, last}));
			last = sp;
		end
		// Driver tristated, coder keeps running
		xfer(1, ra(0, 1), 32'h0000_0012);
		sym(0);
		chk(32'({sp ^ sn, oe[0], pwr[0]}), 32'h0000_0005);
		// Power down stops the transmitter and flushes the line
		xfer(1, ra(0, 0), 32'h0000_0011);
		repeat (2) sym(0);
		chk(32'({sp, sn, oe[0], pwr[0], mon[0]}), 32'h0000_0000);
		xfer(1, ra(0, 0), 32'h0000_0001);
		xfer(1, ra(0, 1), 32'h0000_0022);
		repeat (2) @(posedge hclk);
		chk(32'({oe[0], pwr[0], mon[0]}), 32'h0000_0006);
		sd <= 1'b0;
		repeat (12) sym(0);
		for (int i = 0; i < 4; i++) begin
			sym(0);
			chk(32'({sp, sn}), 32'h0000_0000);
		end
		$display("test ami done");
		// Zero substitution: E1 templates give HDB3, others B8ZS
		xfer(1, ra(0, 0), 32'h0000_0000);
		for (int k = 0; k < 3; k++) begin
			xfer(1, ra(0, 1), tp[k]);
			repeat (12) sym(0);
			for (int i = 0; i < 8; i++) begin
				sym(0);
				m[i] = sp | sn;
			end
			hit = 1'b0;
			for (int i = 0; i < 8; i++) begin
				if (8'({m, m} >> i) == pat[k]) hit = 1'b1;
			end
			chk(32'(hit), 32'h0000_0001);
		end
		$display("test substitution done");
		// Mid-run reset returns the registers to their reset image
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(0, ra(0, 1), 0);
		chk(rd, 32'h0000_0010);
		xfer(0, ra(0, 0), 0);
		chk(rd, 32'h0000_0000);
		// Clock enable low: a write is not taken
		ce <= 1'b0;
		xfer(1, ra(2, 0), 32'h0000_0008);
		ce <= 1'b1;
		xfer(0, ra(2, 0), 0);
		chk(rd, 32'h0000_0000);
		$display("test reset and enable done");
		stop_test();
	end

	// Watchdog, well beyond the expected run length
	initial begin
		repeat (40000) @(posedge hclk);
		error_cnt++;
		$display("watchdog expired at %0t", $time);
		stop_test();
	end
endmodule
